/* File: hw/vlc_idle_watch.sv */
// Purpose: reports a passive bus held for the idle time
// Assumes: filtered receive level, active high
// Notes: disarming clears the count and the report
`timescale 1ns/10ps
module vlc_idle_watch import vlc_pkg::*; #(
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  vlc_rx_if.watch bus
);
  localparam int CW = $clog2(IDLE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_END = CW'(IDLE_CYCLES - 1);
  if (IDLE_CYCLES < 2) begin : g_bad_idle
    $error("vlc_idle_watch: IDLE_CYCLES must be at least 2");
  end
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic idle;
  } vlc_idle_type;
  vlc_idle_type q, d;
  ////////////////////////////////////////////////////////////////////
  // Any active sample restarts the passive-time count
  always_comb begin
    d = q;
    if (!bus.arm || bus.filtered != BUS_PASSIVE) begin
      d.cnt = '0;
      d.idle = 1'b0;
    end else if (q.cnt == CNT_END) d.idle = 1'b1;
    else d.cnt = q.cnt + 1'b1;
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) q <= '0;
    else q <= d;
  end
  assign bus.idle = q.idle;
endmodule // vlc_idle_watch

/* File: hw/vlc_link_controller.sv */
// Purpose: mode control and CPU register bank of the VPW link
// Assumes: CPU strobes and reset sources are on i_clock; rx pin is not
// Notes: symbol coding and framing live in the protocol handler
`timescale 1ns/10ps
module vlc_link_controller import vlc_pkg::*; #(
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_low_voltage_reset,
  input wire logic i_watchdog_reset,
  input wire logic i_pin_reset,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_cpu_running,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_rx_pin,
  output logic o_tx_pin,
  input wire logic i_handler_tx,
  input wire logic i_eof_received,
  output logic o_handler_rx,
  output logic o_handler_enable,
  output logic o_wake_irq,
  output logic o_clocks_run,
  output logic [1:0] o_link_mode
);
  typedef struct packed {
    vlc_mode_type mode;
    logic rx_s1;
    logic rx_s2;
    logic [7:0] roundtrip;
    logic [7:0] ctl_one;
    logic [7:0] ctl_two;
    logic [7:0] data;
    logic wake_act;
    logic wake_eof;
    logic need_idle;
    logic tx;
    logic [7:0] rdata;
    logic irq;
    logic hrx;
    logic henable;
    logic clk_run;
  } vlc_core_type;

  localparam vlc_core_type ST_INIT = '{
    mode: MODE_RESET,
    rx_s1: 1'b0,
    rx_s2: 1'b0,
    roundtrip: RST_ROUNDTRIP,
    ctl_one: RST_CTL_ONE,
    ctl_two: RST_CTL_TWO,
    data: RST_DATA,
    wake_act: 1'b0,
    wake_eof: 1'b0,
    need_idle: 1'b0,
    tx: BUS_PASSIVE,
    rdata: 8'h00,
    irq: 1'b0,
    hrx: BUS_PASSIVE,
    henable: 1'b0,
    clk_run: 1'b1
  };

  vlc_core_type q, d;
  vlc_rx_if rx_bus ();
  logic any_src;
  logic rx_norm;
  logic sv_read;
  logic [3:0] state_code;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////
  // Receive path: filter and idle watch

  vlc_rx_filter #(
    .CNT_W(FILT_CNT_W)
  ) u_filter (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .bus(rx_bus.filt)
  );

  vlc_idle_watch #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .bus(rx_bus.watch)
  );

  ////////////////////////////////////////////////////////////////////
  // Combinational helpers

  // Any system reset source pulls the link into reset mode
  assign any_src = i_low_voltage_reset | i_watchdog_reset | i_pin_reset;

  // Polarity fix after the second synchroniser stage only
  assign rx_norm = q.rx_s2 ^ q.roundtrip[RT_RECEIVE_POLARITY_BIT];

  // Digital loopback swaps the filter input to our own transmit level
  assign rx_bus.sample = q.ctl_two[C2_DIGITAL_LOOPBACK_ENABLE_BIT] ? i_handler_tx : rx_norm;

  // Frozen filter stands in for the halted clocks in stop and reset
  assign rx_bus.hold = (q.mode == MODE_STOP) || (q.mode == MODE_RESET);

  // Idle watch only runs after an analog loopback exit
  assign rx_bus.arm = q.need_idle;

  assign sv_read = i_rd && (i_addr == ADDR_STATE);

  // Activity wake takes priority in the reported code
  always_comb begin
    if (q.wake_act) state_code = SC_WAKE_ACT;
    else if (q.wake_eof) state_code = SC_WAKE_EOF;
    else state_code = SC_NONE;
  end

  // Read data, reserved bits forced to zero
  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      ADDR_ROUNDTRIP: rd_mux = q.roundtrip & ROUNDTRIP_WMASK;
      ADDR_CTL_ONE: rd_mux = q.ctl_one & CTL_ONE_WMASK;
      ADDR_CTL_TWO: rd_mux = q.ctl_two;
      ADDR_STATE: rd_mux[SV_LSB +: SV_W] = state_code;
      ADDR_DATA: rd_mux = q.data;
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.rx_s1 = i_rx_pin;
    d.rx_s2 = q.rx_s1;

    // Register writes; the state vector takes none
    if (i_wr && q.mode != MODE_RESET) begin
      case (i_addr)
        ADDR_ROUNDTRIP: d.roundtrip = i_wdata & ROUNDTRIP_WMASK;
        ADDR_CTL_ONE: d.ctl_one = i_wdata & CTL_ONE_WMASK;
        ADDR_CTL_TWO: d.ctl_two = i_wdata;
        ADDR_DATA: d.data = i_wdata;
        default: d.data = q.data;
      endcase
    end

    // Register read; reading the state vector is the acknowledge
    if (i_rd) d.rdata = rd_mux;
    if (sv_read) begin
      d.wake_act = 1'b0;
      d.wake_eof = 1'b0;
    end

    // Mode sequencing; wake sets come after the clear so they win
    case (q.mode)
      MODE_RESET: begin
        if (!any_src) d.mode = MODE_RUN;
      end
      MODE_RUN: begin
        // Software must have drained transmissions before this point
        if (i_stop_exec || (i_wait_exec && q.ctl_one[C1_WCM_BIT])) begin
          d.mode = MODE_STOP;
        end else if (i_wait_exec) begin
          d.mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (rx_bus.rise) begin
          d.wake_act = 1'b1;
          d.mode = MODE_RUN;
        end else if (i_eof_received) begin
          d.wake_eof = 1'b1;
          d.mode = MODE_RUN;
        end
      end
      MODE_STOP: begin
        // Unfiltered level: the filter is frozen while stopped
        if (rx_norm == BUS_ACTIVE) begin
          d.wake_act = 1'b1;
          d.mode = MODE_RUN;
        end
      end
      default: d.mode = MODE_RESET;
    endcase

    // Leaving analog loopback demands a quiet bus; exit beats idle
    if (q.ctl_two[C2_ANALOG_LOOPBACK_ENABLE_BIT] && !d.ctl_two[C2_ANALOG_LOOPBACK_ENABLE_BIT]) begin
      d.need_idle = 1'b1;
    end else if (rx_bus.idle) begin
      d.need_idle = 1'b0;
    end

    // Pin and handler outputs; the pin is passive outside run and wait, the handler receive level follows the filter
    if (q.ctl_two[C2_DIGITAL_LOOPBACK_ENABLE_BIT] || d.mode == MODE_RESET || d.mode == MODE_STOP) begin
      d.tx = BUS_PASSIVE;
    end else begin
      d.tx = i_handler_tx;
    end
    d.hrx = rx_bus.filtered;
    d.henable = (d.mode == MODE_RUN) && i_cpu_running && !d.need_idle;
    d.irq = d.wake_act || d.wake_eof;
    d.clk_run = (d.mode != MODE_STOP);

    // Reset mode: all but the rx synchroniser back to its reset value, other inputs ignored
    if (any_src) begin
      d = ST_INIT;
      d.rx_s1 = i_rx_pin;
      d.rx_s2 = q.rx_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) q <= ST_INIT;
    else q <= d;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, straight from the state register

  assign o_rdata = q.rdata;
  assign o_tx_pin = q.tx;
  assign o_handler_rx = q.hrx;
  assign o_handler_enable = q.henable;
  assign o_wake_irq = q.irq;
  assign o_clocks_run = q.clk_run;
  assign o_link_mode = q.mode;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // Wait-mode wake: edge seen, then run with request raised
  sequence s_wait_edge;
    q.mode == MODE_WAIT && rx_bus.rise && !any_src;
  endsequence
  sequence s_woken_run;
    q.mode == MODE_RUN && q.wake_act ##1 o_wake_irq;
  endsequence

  chk_reset_entry: assert property (any_src |=> q.mode == MODE_RESET)
    else $error("reset source did not force reset mode");

  chk_reset_values: assert property (any_src |=>
    q.ctl_two == RST_CTL_TWO && o_tx_pin == BUS_PASSIVE && !o_wake_irq)
    else $error("reset mode left state or outputs off reset");

  chk_run_release: assert property (
    q.mode == MODE_RESET && !any_src |=> q.mode == MODE_RUN)
    else $error("release did not reach run mode");

  chk_wait_wake: assert property (s_wait_edge |=> s_woken_run)
    else $error("bus edge in wait did not wake");

  chk_stop_wake: assert property (
    q.mode == MODE_STOP && rx_norm && !any_src |=> q.mode == MODE_RUN ##1 o_clocks_run)
    else $error("activity in stop did not restart");

  chk_wait_entry: assert property (
    q.mode == MODE_RUN && i_wait_exec && !i_stop_exec && !q.ctl_one[C1_WCM_BIT]
    && !any_src |=> q.mode == MODE_WAIT)
    else $error("wait instruction did not enter wait mode");

  chk_eof_wake: assert property (
    q.mode == MODE_WAIT && !rx_bus.rise && i_eof_received && !any_src
    |=> q.wake_eof ##1 o_wake_irq)
    else $error("end-of-frame in wait did not wake");

  chk_stop_entry: assert property (
    q.mode == MODE_RUN && (i_stop_exec || (i_wait_exec && q.ctl_one[C1_WCM_BIT]))
    && !any_src |=> q.mode == MODE_STOP ##1 !o_clocks_run)
    else $error("stop request did not enter stop mode");

  chk_digital_loopback_enable_quiet: assert property (
    q.ctl_two[C2_DIGITAL_LOOPBACK_ENABLE_BIT] |=> o_tx_pin == BUS_PASSIVE)
    else $error("bus driven during digital loopback");

  chk_analog_loopback_enable_idle: assert property (
    q.ctl_two[C2_ANALOG_LOOPBACK_ENABLE_BIT] && !d.ctl_two[C2_ANALOG_LOOPBACK_ENABLE_BIT] && !any_src
    |=> q.need_idle ##1 !o_handler_enable)
    else $error("handler enabled before idle after loopback");

  chk_state_vector: assert property (
    sv_read |=> o_rdata[7:6] == 2'b00 && o_rdata[1:0] == 2'b00)
    else $error("state vector reserved bits not zero");

  chk_irq_hold: assert property (
    o_wake_irq && !i_rd && !any_src |=> o_wake_irq)
    else $error("wake request dropped without acknowledge");

  chk_tx_follow: assert property (
    q.mode == MODE_RUN && !q.ctl_two[C2_DIGITAL_LOOPBACK_ENABLE_BIT] && !i_stop_exec && !i_wait_exec
    && !any_src |=> o_tx_pin == $past(i_handler_tx))
    else $error("transmit pin did not follow the handler");

  chk_rx_follow: assert property (
    !any_src |=> o_handler_rx == $past(rx_bus.filtered))
    else $error("handler receive level is not the filtered one");

  chk_reset_quiet: assert property (
    q.mode == MODE_RESET |-> !o_handler_enable && !o_wake_irq && o_tx_pin == BUS_PASSIVE)
    else $error("output left its reset level in reset mode");

  chk_clock_halt: assert property (
    q.mode == MODE_STOP |-> !o_clocks_run)
    else $error("clocks running in stop mode");

endmodule // vlc_link_controller

/* File: hw/vlc_pkg.sv */
// Purpose: shared constants and types of the VPW link mode controller
// Assumes: 20 MHz core clock, 8-bit CPU register port
// Notes: register reset values are plain zero defaults
package vlc_pkg;
  // Register byte offsets on the CPU port
  localparam logic [7:0] ADDR_ROUNDTRIP = 8'h3b;
  localparam logic [7:0] ADDR_CTL_ONE = 8'h3c;
  localparam logic [7:0] ADDR_CTL_TWO = 8'h3d;
  localparam logic [7:0] ADDR_STATE = 8'h3e;
  localparam logic [7:0] ADDR_DATA = 8'h3f;
  // Reset values
  localparam logic [7:0] RST_ROUNDTRIP = 8'h00;
  localparam logic [7:0] RST_CTL_ONE = 8'h00;
  localparam logic [7:0] RST_CTL_TWO = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  // Writable bits; reserved bits hold zero
  localparam logic [7:0] ROUNDTRIP_WMASK = 8'hcf;
  localparam logic [7:0] CTL_ONE_WMASK = 8'hf3;
  // Field positions
  localparam int RT_RECEIVE_POLARITY_BIT = 6;
  localparam int C1_WCM_BIT = 0;
  localparam int C2_ANALOG_LOOPBACK_ENABLE_BIT = 7;
  localparam int C2_DIGITAL_LOOPBACK_ENABLE_BIT = 6;
  localparam int SV_LSB = 2;
  localparam int SV_W = 4;
  // State codes shown in the state vector
  localparam logic [3:0] SC_NONE = 4'h0;
  localparam logic [3:0] SC_WAKE_ACT = 4'h1;
  localparam logic [3:0] SC_WAKE_EOF = 4'h2;
  // Bus levels after polarity correction
  localparam logic BUS_PASSIVE = 1'b0;
  localparam logic BUS_ACTIVE = 1'b1;
  // Filter counter width; top count is all ones (15)
  localparam int FILT_CNT_W = 4;
  // Idle bus time before rejoining the network
  localparam int CLOCK_KHZ = 20000;
  localparam int BUS_IDLE_US = 280;
  localparam int IDLE_CYCLES_DEF = (BUS_IDLE_US * CLOCK_KHZ + 999) / 1000;
  typedef enum logic [1:0] {
    MODE_RESET,
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP
  } vlc_mode_type;
endpackage

/* File: hw/vlc_rx_filter.sv */
// Purpose: saturating up/down noise filter on the receive line
// Assumes: sample already synchronised
// Notes: delay from input change to output is the full count span
`timescale 1ns/10ps
module vlc_rx_filter import vlc_pkg::*; #(
  parameter int CNT_W = FILT_CNT_W
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  vlc_rx_if.filt bus
);
  localparam logic [CNT_W-1:0] CNT_TOP = {CNT_W{1'b1}};
  if (CNT_W < 2) begin : g_bad_width
    $error("vlc_rx_filter: CNT_W must be at least 2");
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic out;
    logic rise;
  } vlc_filt_type;
  vlc_filt_type q, d;
  ////////////////////////////////////////////////////////////////////
  // Count toward the sample, latch only at the end points
  always_comb begin
    d = q;
    d.rise = 1'b0;
    if (!bus.hold) begin
      if (bus.sample && q.cnt != CNT_TOP) d.cnt = q.cnt + 1'b1;
      else if (!bus.sample && q.cnt != '0) d.cnt = q.cnt - 1'b1;
      if (q.cnt == CNT_TOP) d.out = 1'b1;
      else if (q.cnt == '0) d.out = 1'b0;
      d.rise = d.out && !q.out;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) q <= '0;
    else q <= d;
  end
  assign bus.filtered = q.out;
  assign bus.rise = q.rise;
  chk_filter_ends: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !bus.hold && q.cnt == '0 && !bus.sample |=> q.cnt == '0 && !q.out)
    else $error("filter left bottom on low sample");
endmodule // vlc_rx_filter

/* File: hw/vlc_rx_if.sv */
// Purpose: carries the receive path between core, filter and idle watch
// Assumes: all signals on i_clock
// Notes: none
`timescale 1ns/10ps
interface vlc_rx_if;
  logic sample;
  logic hold;
  logic filtered;
  logic rise;
  logic arm;
  logic idle;
  modport filt (input sample, input hold, output filtered, output rise);
  modport watch (input filtered, input arm, output idle);
  modport core (output sample, output hold, output arm,
    input filtered, input rise, input idle);
endinterface

/* File: test/test_vlc_link_controller.sv */
// Purpose: self-checking bench of the link mode controller
// Assumes: 20 MHz clock, idle watch shortened to 8 cycles
// Notes: read results go through a queue checked by a monitor
`timescale 1ns/10ps
module test_vlc_link_controller;
  import vlc_pkg::*;
  logic i_clock, i_rst_n, i_low_voltage_reset, i_watchdog_reset, i_pin_reset;
  logic i_wait_exec, i_stop_exec, i_cpu_running, i_wr, i_rd, i_handler_tx;
  logic i_eof_received, i_rx_pin, o_tx_pin, o_handler_rx, o_handler_enable;
  logic o_wake_irq, o_clocks_run, other_active, rd_p;
  logic [7:0] i_addr, i_wdata, o_rdata, d;
  logic [1:0] o_link_mode;
  logic [7:0] exp_q[$];
  int err_count, cmp_count, cyc;
  vlc_link_controller #(.IDLE_CYCLES(8)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_low_voltage_reset(i_low_voltage_reset), .i_watchdog_reset(i_watchdog_reset),
    .i_pin_reset(i_pin_reset), .i_wait_exec(i_wait_exec), .i_stop_exec(i_stop_exec),
    .i_cpu_running(i_cpu_running), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rx_pin(i_rx_pin), .o_tx_pin(o_tx_pin),
    .i_handler_tx(i_handler_tx), .i_eof_received(i_eof_received),
    .o_handler_rx(o_handler_rx), .o_handler_enable(o_handler_enable),
    .o_wake_irq(o_wake_irq), .o_clocks_run(o_clocks_run), .o_link_mode(o_link_mode));
  vlc_bus_model #(.DELAY_NS(120)) bus (.i_tx(o_tx_pin), .i_other_active(other_active),
    .o_rx(i_rx_pin));
  //////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  // Bounded wait, never a fixed guess at latency
  task automatic await_mode(input vlc_mode_type m);
    int n;
    n = 0;
    while (o_link_mode !== m && n < 60) begin
      @(negedge i_clock);
      n++;
    end
    check({6'h00, o_link_mode}, {6'h00, m});
  endtask
  task automatic await_out(input bit sel, input int lim);
    int n;
    n = 0;
    while ((sel ? o_handler_enable : o_handler_rx) !== 1'b1 && n < lim) begin
      @(negedge i_clock);
      n++;
    end
  endtask
  task automatic power_down(input bit use_stop);
    // Software sleeps only once its transmitter is quiet
    @(negedge i_clock);
    check({7'h00, o_tx_pin}, 8'h00);
    @(posedge i_clock);
    if (use_stop) i_stop_exec <= 1'b1;
    else i_wait_exec <= 1'b1;
    @(posedge i_clock);
    i_stop_exec <= 1'b0;
    i_wait_exec <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////
  // Monitor: oldest queued note against each read answer
  always @(posedge i_clock) rd_p <= i_rd;
  always @(negedge i_clock) begin
    if (rd_p && exp_q.size() > 0) check(o_rdata, exp_q.pop_front());
  end
  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_rst_n, i_low_voltage_reset, i_watchdog_reset, i_pin_reset} = 4'h0;
    {i_wait_exec, i_stop_exec, i_wr, i_rd, i_handler_tx, i_eof_received} = 6'h00;
    i_cpu_running = 1'b1;
    other_active = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    rd_p = 1'b0;
    void'($urandom(32'hd2dc41a0));
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    await_mode(MODE_RUN);
    check({7'h00, o_clocks_run}, 8'h01);
    // Reset values, then masked write and readback; 0x40 is unmapped
    for (int i = 0; i < 6; i++) rd(ADDR_ROUNDTRIP + i[7:0], 8'h00);
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      wr(ADDR_ROUNDTRIP + i[7:0], (i == 2) ? (d & 8'h3f) : d);
      rd(ADDR_ROUNDTRIP + i[7:0], (i == 0) ? (d & ROUNDTRIP_WMASK) : (i == 1) ?
        (d & CTL_ONE_WMASK) : (i == 2) ? (d & 8'h3f) : (i == 3) ? 8'h00 : d);
    end
    d = 8'h00;
    wr(ADDR_ROUNDTRIP, 8'h00);
    wr(ADDR_CTL_ONE, 8'h00);
    // A random polarity bit may have lifted the filter; let it settle
    repeat (25) @(negedge i_clock);
    // Wait mode woken by bus activity; software has stopped sending first
    power_down(1'b0);
    await_mode(MODE_WAIT);
    other_active <= 1'b1;
    await_mode(MODE_RUN);
    @(negedge i_clock);
    check({7'h00, o_wake_irq}, 8'h01);
    repeat (5) @(negedge i_clock);
    check({7'h00, o_wake_irq}, 8'h01);
    other_active <= 1'b0;
    rd(ADDR_STATE, 8'h04);
    repeat (2) @(negedge i_clock);
    check({7'h00, o_wake_irq}, 8'h00);
    repeat (25) @(negedge i_clock);
    // End of frame: ignored in run, wakes in wait
    for (int k = 0; k < 2; k++) begin
      if (k == 1) power_down(1'b0);
      if (k == 1) await_mode(MODE_WAIT);
      @(posedge i_clock);
      i_eof_received <= 1'b1;
      @(posedge i_clock);
      i_eof_received <= 1'b0;
      await_mode(MODE_RUN);
      rd(ADDR_STATE, (k == 1) ? 8'h08 : 8'h00);
    end
    // Stop by stop instruction, then by wait with clock select set
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(ADDR_CTL_ONE, 8'h01);
      power_down(k == 0);
      await_mode(MODE_STOP);
      check({7'h00, o_clocks_run}, 8'h00);
      // CPU still asleep when the bus wakes the link
      @(posedge i_clock);
      i_cpu_running <= 1'b0;
      other_active <= 1'b1;
      await_mode(MODE_RUN);
      @(negedge i_clock);
      check({7'h00, o_clocks_run}, 8'h01);
      check({7'h00, o_handler_enable}, 8'h00);
      rd(ADDR_STATE, 8'h04);
      i_cpu_running <= 1'b1;
      other_active <= 1'b0;
      repeat (25) @(negedge i_clock);
      check({7'h00, o_handler_enable}, 8'h01);
    end
    wr(ADDR_CTL_ONE, 8'h00);
    // Digital loopback: filtered echo, bus never driven
    wr(ADDR_CTL_TWO, 8'h40);
    @(posedge i_clock);
    i_handler_tx <= 1'b1;
    repeat (10) @(negedge i_clock);
    check({7'h00, o_handler_rx}, 8'h00);
    await_out(1'b0, 30);
    check({7'h00, o_handler_rx}, 8'h01);
    check({7'h00, o_tx_pin}, 8'h00);
    @(posedge i_clock);
    i_handler_tx <= 1'b0;
    wr(ADDR_CTL_TWO, 8'h00);
    repeat (25) @(negedge i_clock);
    // Normal transmit path, one cycle through
    @(posedge i_clock);
    i_handler_tx <= 1'b1;
    repeat (2) @(negedge i_clock);
    check({7'h00, o_tx_pin}, 8'h01);
    @(posedge i_clock);
    i_handler_tx <= 1'b0;
    repeat (25) @(negedge i_clock);
    // Analog loopback exit holds the handler off until the bus idles
    wr(ADDR_CTL_TWO, 8'h80);
    @(negedge i_clock);
    check({7'h00, o_handler_enable}, 8'h01);
    wr(ADDR_CTL_TWO, 8'h00);
    @(negedge i_clock);
    check({7'h00, o_handler_enable}, 8'h00);
    repeat (4) @(negedge i_clock);
    check({7'h00, o_handler_enable}, 8'h00);
    await_out(1'b1, 40);
    check({7'h00, o_handler_enable}, 8'h01);
    // Receive polarity inverts the pin: a passive bus reads active
    wr(ADDR_ROUNDTRIP, 8'h40);
    await_out(1'b0, 40);
    check({7'h00, o_handler_rx}, 8'h01);
    wr(ADDR_ROUNDTRIP, 8'h00);
    // Every reset source forces reset mode and clears registers
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_DATA, 8'h5a);
      @(posedge i_clock);
      {i_low_voltage_reset, i_watchdog_reset, i_pin_reset} <= 3'b001 << s;
      await_mode(MODE_RESET);
      wr(ADDR_DATA, 8'ha5);
      rd(ADDR_DATA, 8'h00);
      {i_low_voltage_reset, i_watchdog_reset, i_pin_reset} <= 3'b000;
      await_mode(MODE_RUN);
      rd(ADDR_DATA, 8'h00);
    end
    repeat (3) @(negedge i_clock);
    complete_run();
  end
endmodule // test_vlc_link_controller

/* File: test/vlc_bus_model.sv */
// Purpose: transceiver and single-wire bus seen from the link pins
// Assumes: pin level high means bus active, no polarity inversion
// Notes: passive bus is pulled low, so a released line reads passive
`timescale 1ns/10ps
module vlc_bus_model #(
  parameter int DELAY_NS = 0
) (
  input wire logic i_tx,
  input wire logic i_other_active,
  output logic o_rx
);
  //////////////////////////////////////////////////////////////////
  // Wired-or bus; the delay models a slow transceiver path
  assign #(DELAY_NS) o_rx = i_tx | i_other_active;
endmodule // vlc_bus_model
